/* File: logic/mfi_pkg.sv */
// Package for the message FIFO interface: address layout, depths and timing.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package mfi_pkg;
  localparam int          DATA_W        = 32;
  localparam int          FIFO_BYTES    = 4096;
  localparam int          FIFO_DEPTH    = FIFO_BYTES / 4;
  localparam int          ADDR_W        = 16;
  localparam int          CNT_W         = 11;
  // Byte addresses inside the block
  localparam logic [15:0] ADR_FIFO_LO   = 16'h0000;  // Ordinary words, also reads
  localparam logic [15:0] ADR_FIFO_HI   = 16'h8000;  // Final word of a message
  localparam logic [15:0] ADR_STATUS    = 16'h7000;  // Status word in lower half, above FIFO window
  localparam logic [15:0] ADR_CTRL      = 16'h7004;  // Control word
  localparam int          HALF_BIT      = 15;        // Address bit that selects upper half
  localparam logic [15:0] FIFO_SPAN     = 16'h1000;  // Lower-half FIFO window size
  // Status bits
  localparam int          ST_END_PRES   = 0;
  localparam int          ST_LAST_END   = 1;
  localparam int          ST_TX_EMPTY   = 2;
  localparam int          ST_RX_EMPTY   = 3;
  localparam int          ST_TX_FULL    = 4;
  localparam int          ST_RX_FULL    = 5;
  localparam int          CT_SLAVE      = 0;         // Module drives the link
  localparam int          CT_MASK       = 1;         // End-present interrupt enable
  // Access timing in clocks
  localparam int          WR_FIRST_CLK  = 5;
  localparam int          WR_NEXT_CLK   = 2;
  localparam int          RD_FIRST_CLK  = 5;
  localparam int          RD_NEXT_CLK   = 3;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          FIFO_ACC_PS   = 25000;     // FIFO access time
  localparam int          FIFO_ACC_CLK  = (FIFO_ACC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

/* File: logic/mfi_fifo_mem.sv */
// Word memory with registered read, one per FIFO direction.
// Assumes one clock; write and read may hit the same slot in one cycle.
`timescale 1ns/1ps
module mfi_fifo_mem #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic             aclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port and registered read port; read data come from a flop
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: logic/mfi_top.sv */
// Message FIFO interface: AXI4-Lite slave, transmit/receive FIFOs and module link.
// Assumes the routing module runs on aclk, so its handshake pins are read directly.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mfi_top #(
  parameter int DEPTH = mfi_pkg::FIFO_DEPTH,
  parameter int AW    = 10
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_word_ready_n,
  input  wire logic        rx_end_marker_n,
  input  wire logic [31:0] rx_data,
  output logic             rx_word_ack_n,
  input  wire logic        tx_space_ready_n,
  output logic             tx_word_ack_n,
  output logic             tx_end_marker_n,
  output logic [31:0]      tx_data,
  output logic             msg_end_present,
  output logic             end_irq
);
  localparam int W = mfi_pkg::DATA_W + 1;

  typedef enum logic [2:0] {
    MFI_IDLE  = 3'b000,
    MFI_WAIT  = 3'b001,
    MFI_WRESP = 3'b010,
    MFI_RFIRE = 3'b011,
    MFI_RRESP = 3'b100
  } mfi_bus_e;

  typedef struct packed {
    mfi_bus_e         bus;
    logic [3:0]       cnt;      // Access wait counter
    logic             wr_seq;   // Last completed FIFO access was a write
    logic             rd_seq;   // Last completed FIFO access was a read
    logic             is_wr;
    logic [15:0]      addr;
    logic [W-1:0]     wbuf;     // Latching buffer toward transmit FIFO
    logic [31:0]      rdat;     // Latching buffer from receive FIFO
    logic [1:0]       resp;
    logic [AW:0]      tx_wp, tx_rp, rx_wp, rx_rp;
    logic [mfi_pkg::CNT_W-1:0] end_cnt;
    logic             last_end;
    logic             slave;
    logic             irq_en;
    logic             turn_tx;  // Alternation token
    logic             tx_fresh;  // Word just pushed; memory output not yet updated
    logic             full_strb; // Write strobes latched at acceptance
    logic             tx_ack, rx_ack, tx_end;
    logic [31:0]      tx_d;
  } mfi_state_s;

  mfi_state_s st_r, st_nxt;
  logic [W-1:0] tx_q, rx_q;
  logic [AW-1:0] tx_ra, rx_ra;
  logic          tx_we, rx_we;
  logic [W-1:0]  rx_wd;
  logic [AW:0]   tx_rp_nx, rx_rp_nx;

  function automatic logic is_full(input logic [AW:0] wp, input logic [AW:0] rp);
    is_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  endfunction

  function automatic logic [AW:0] inc(input logic [AW:0] p);
    inc = p + (AW+1)'(1);
  endfunction

  logic tx_empty, rx_empty, tx_full, rx_full;
  logic mod_rx_ok, mod_tx_ok, do_rx, do_tx, pop_tx;
  logic is_fifo_w, is_fifo_r;

  always_comb begin
    tx_empty = st_r.tx_wp == st_r.tx_rp;
    rx_empty = st_r.rx_wp == st_r.rx_rp;
    tx_full  = is_full(st_r.tx_wp, st_r.tx_rp);
    rx_full  = is_full(st_r.rx_wp, st_r.rx_rp);
  end

  // Memories read next pointer on a pop so fall-through costs no cycle
  assign tx_rp_nx = inc(st_r.tx_rp);
  assign rx_rp_nx = inc(st_r.rx_rp);
  assign tx_ra = pop_tx ? tx_rp_nx[AW-1:0] : st_r.tx_rp[AW-1:0];
  assign rx_ra = (st_r.bus == MFI_RFIRE && is_fifo_r) ?
                 rx_rp_nx[AW-1:0] : st_r.rx_rp[AW-1:0];
  assign rx_we = do_rx;
  assign rx_wd = {~rx_end_marker_n, rx_data};
  // A refused write must not touch the slot that the read side may be showing
  assign tx_we = (st_r.bus == MFI_WRESP) && is_fifo_w && (st_r.resp == mfi_pkg::RESP_OKAY);

  mfi_fifo_mem #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_tx_mem (
    .aclk  (aclk),
    .we    (tx_we),
    .waddr (st_r.tx_wp[AW-1:0]),
    .wdata (st_r.wbuf),
    .raddr (tx_ra),
    .rdata (tx_q)
  );

  mfi_fifo_mem #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_rx_mem (
    .aclk  (aclk),
    .we    (rx_we),
    .waddr (st_r.rx_wp[AW-1:0]),
    .wdata (rx_wd),
    .raddr (rx_ra),
    .rdata (rx_q)
  );

  // Link arbitration on the pins directly: the module shares aclk, and a delayed
  // view of ready would see a dropped ready late and take one word twice
  always_comb begin
    mod_rx_ok = !rx_word_ready_n && !rx_full && !st_r.rx_ack;
    mod_tx_ok = !tx_space_ready_n && !tx_empty && !st_r.tx_ack &&
                !st_r.tx_fresh;
    do_rx = mod_rx_ok && (!mod_tx_ok || !st_r.turn_tx);
    do_tx = mod_tx_ok && (!mod_rx_ok || st_r.turn_tx);
    pop_tx = do_tx;
    // Upper half writes and anything in lower FIFO window are FIFO accesses
    is_fifo_w = st_r.addr[mfi_pkg::HALF_BIT] ||
                (st_r.addr < mfi_pkg::FIFO_SPAN);
    is_fifo_r = ({1'b0, st_r.addr[mfi_pkg::HALF_BIT-1:0]} < mfi_pkg::FIFO_SPAN) ||
                st_r.addr[mfi_pkg::HALF_BIT];
  end

  // Next state of bus slave, link and counters
  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_ack = 1'b0;
    st_nxt.tx_ack = 1'b0;
    // Memory output catches up one clock after a push
    st_nxt.tx_fresh = 1'b0;
    // In slave mode the module's ready is taken as its own strobe; the ack pins stay
    // high, but the idle cycle after each transfer is kept
    if (do_rx) begin
      st_nxt.rx_ack  = 1'b1;
      st_nxt.rx_wp   = inc(st_r.rx_wp);
      st_nxt.turn_tx = 1'b1;
    end
    if (do_tx) begin
      st_nxt.tx_ack  = 1'b1;
      st_nxt.tx_end  = tx_q[mfi_pkg::DATA_W];
      st_nxt.tx_d    = tx_q[31:0];
      st_nxt.tx_rp   = inc(st_r.tx_rp);
      st_nxt.turn_tx = 1'b0;
    end
    unique case (st_r.bus)
      MFI_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          st_nxt.is_wr = 1'b1;
          st_nxt.addr  = s_axi_awaddr;
          st_nxt.wbuf  = {s_axi_awaddr[mfi_pkg::HALF_BIT], s_axi_wdata};
          // The master may drop its strobes after the handshake, so keep them here
          st_nxt.full_strb = (s_axi_wstrb == 4'hF);
          st_nxt.cnt   = st_r.wr_seq ? 4'(mfi_pkg::WR_NEXT_CLK - 2)
                                     : 4'(mfi_pkg::WR_FIRST_CLK - 2);
          st_nxt.bus   = MFI_WAIT;
        end else if (s_axi_arvalid) begin
          st_nxt.is_wr = 1'b0;
          st_nxt.addr  = s_axi_araddr;
          st_nxt.cnt   = st_r.rd_seq ? 4'(mfi_pkg::RD_NEXT_CLK - 2)
                                     : 4'(mfi_pkg::RD_FIRST_CLK - 2);
          st_nxt.bus   = MFI_WAIT;
        end
      end
      MFI_WAIT: begin
        if (st_r.cnt != 4'h0) begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end else if (st_r.is_wr) begin
          st_nxt.resp = (is_fifo_w && !st_r.full_strb) ?
                        mfi_pkg::RESP_SLVERR : mfi_pkg::RESP_OKAY;
          // Hold while the transmit FIFO is full
          if (!(is_fifo_w && tx_full && st_r.full_strb)) begin
            st_nxt.bus = MFI_WRESP;
          end
        end else if (!(is_fifo_r && rx_empty)) begin
          st_nxt.bus = MFI_RFIRE;
        end
      end
      MFI_WRESP: begin
        if (is_fifo_w && st_r.resp == mfi_pkg::RESP_OKAY) begin
          st_nxt.tx_wp  = inc(st_r.tx_wp);
          st_nxt.wr_seq = 1'b1;
          st_nxt.rd_seq = 1'b0;
          st_nxt.last_end = 1'b0;
          st_nxt.tx_fresh = 1'b1;
        end else if (st_r.addr == mfi_pkg::ADR_CTRL) begin
          st_nxt.slave  = st_r.wbuf[mfi_pkg::CT_SLAVE];
          st_nxt.irq_en = st_r.wbuf[mfi_pkg::CT_MASK];
        end
        st_nxt.resp = (is_fifo_w || st_r.addr == mfi_pkg::ADR_CTRL) ?
                      st_nxt.resp : mfi_pkg::RESP_SLVERR;
        if (st_r.addr == mfi_pkg::ADR_CTRL) begin
          st_nxt.resp = mfi_pkg::RESP_OKAY;
        end
        st_nxt.bus = MFI_RRESP;
      end
      MFI_RFIRE: begin
        st_nxt.resp = mfi_pkg::RESP_OKAY;
        if (is_fifo_r) begin
          st_nxt.rdat   = rx_q[31:0];
          st_nxt.rx_rp  = inc(st_r.rx_rp);
          st_nxt.rd_seq = 1'b1;
          st_nxt.wr_seq = 1'b0;
          st_nxt.last_end = rx_q[mfi_pkg::DATA_W];
        end else if (st_r.addr == mfi_pkg::ADR_STATUS) begin
          st_nxt.rdat = '0;
          st_nxt.rdat[mfi_pkg::ST_END_PRES] = st_r.end_cnt != '0;
          st_nxt.rdat[mfi_pkg::ST_LAST_END] = st_r.last_end;
          st_nxt.rdat[mfi_pkg::ST_TX_EMPTY] = tx_empty;
          st_nxt.rdat[mfi_pkg::ST_RX_EMPTY] = rx_empty;
          st_nxt.rdat[mfi_pkg::ST_TX_FULL]  = tx_full;
          st_nxt.rdat[mfi_pkg::ST_RX_FULL]  = rx_full;
        end else if (st_r.addr == mfi_pkg::ADR_CTRL) begin
          st_nxt.rdat = '0;
          st_nxt.rdat[mfi_pkg::CT_SLAVE] = st_r.slave;
          st_nxt.rdat[mfi_pkg::CT_MASK]  = st_r.irq_en;
        end else begin
          st_nxt.rdat = '0;
          st_nxt.resp = mfi_pkg::RESP_SLVERR;
        end
        st_nxt.bus = MFI_RRESP;
      end
      MFI_RRESP: begin
        if (st_r.is_wr ? s_axi_bready : s_axi_rready) begin
          st_nxt.bus = MFI_IDLE;
        end
      end
      default: st_nxt.bus = MFI_IDLE;
    endcase
    // Counter: arrival and read of marked words may coincide
    st_nxt.end_cnt = st_r.end_cnt
                   + mfi_pkg::CNT_W'(do_rx && !rx_end_marker_n)
                   - mfi_pkg::CNT_W'(st_r.bus == MFI_RFIRE && is_fifo_r &&
                                     rx_q[mfi_pkg::DATA_W]);
    if (!aresetn) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  // Bus handshakes; write response waits in RRESP, shared with reads
  assign s_axi_awready   = (st_r.bus == MFI_IDLE) && s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready    = s_axi_awready;
  assign s_axi_arready   = (st_r.bus == MFI_IDLE) && !(s_axi_awvalid && s_axi_wvalid);
  assign s_axi_bvalid    = (st_r.bus == MFI_RRESP) && st_r.is_wr;
  assign s_axi_rvalid    = (st_r.bus == MFI_RRESP) && !st_r.is_wr;
  assign s_axi_bresp     = st_r.resp;
  assign s_axi_rresp     = st_r.resp;
  assign s_axi_rdata     = st_r.rdat;
  assign rx_word_ack_n   = !(st_r.rx_ack && !st_r.slave);
  assign tx_word_ack_n   = !(st_r.tx_ack && !st_r.slave);
  assign tx_end_marker_n = !(st_r.tx_ack && st_r.tx_end);
  assign tx_data         = st_r.tx_d;
  assign msg_end_present = st_r.end_cnt != '0;
  assign end_irq         = msg_end_present && st_r.irq_en;

  a_end_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_end_present == (st_r.end_cnt != '0)) else $error("end flag wrong");
  a_no_tx_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    do_tx |-> !tx_empty) else $error("tx pop from empty");
  a_no_rx_full: assert property (@(posedge aclk) disable iff (!aresetn)
    do_rx |-> !rx_full) else $error("rx push when full");
  a_alternate: assert property (@(posedge aclk) disable iff (!aresetn)
    (mod_rx_ok && mod_tx_ok) |-> (do_rx != do_tx)) else $error("no alternation");
  a_cnt_up: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_rx && !rx_end_marker_n && st_r.bus != MFI_RFIRE) |=>
    st_r.end_cnt == $past(st_r.end_cnt) + 1'b1) else $error("counter no inc");
  a_ack_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_word_ack_n |=> rx_word_ack_n) else $error("ack not one cycle");
  a_last_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_we && st_r.resp == mfi_pkg::RESP_OKAY) |=> !st_r.last_end) else $error("last not cleared");
  a_wr_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_IDLE && s_axi_awready && !st_r.wr_seq) |=>
    st_r.cnt == 4'(mfi_pkg::WR_FIRST_CLK - 2)) else $error("write timing");

  // Access counters loaded at acceptance for pipelined and first accesses
  a_wr_next: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_IDLE && s_axi_awready && st_r.wr_seq) |=>
    st_r.cnt == 4'(mfi_pkg::WR_NEXT_CLK - 2))
    else $error("write pipeline timing");
  a_rd_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arready && s_axi_arvalid && !st_r.rd_seq) |=>
    st_r.cnt == 4'(mfi_pkg::RD_FIRST_CLK - 2))
    else $error("read timing");
  a_rd_next: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arready && s_axi_arvalid && st_r.rd_seq) |=>
    st_r.cnt == 4'(mfi_pkg::RD_NEXT_CLK - 2))
    else $error("read pipeline timing");

  // End marker, end counter and last-read flag
  a_end_word: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_IDLE && s_axi_awready) |=>
    st_r.wbuf[mfi_pkg::DATA_W] == $past(s_axi_awaddr[mfi_pkg::HALF_BIT]))
    else $error("end bit not set");
  a_cnt_down: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_RFIRE && is_fifo_r && rx_q[mfi_pkg::DATA_W] &&
     !(do_rx && !rx_end_marker_n)) |=> st_r.end_cnt == $past(st_r.end_cnt) - 1'b1)
    else $error("counter no dec");
  a_last_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_RFIRE && is_fifo_r) |=>
    st_r.last_end == $past(rx_q[mfi_pkg::DATA_W]))
    else $error("last read flag not latched");

  // Refused writes, stale memory output and link handshake order
  a_refused_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.bus == MFI_WRESP && st_r.resp != mfi_pkg::RESP_OKAY) |=>
    st_r.tx_wp == $past(st_r.tx_wp))
    else $error("refused write pushed");
  a_fresh_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_we |=> !do_tx)
    else $error("pop of stale word");
  a_end_with_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tx_end_marker_n && !st_r.slave) |-> !tx_word_ack_n)
    else $error("end marker without ack");
  a_ack_after_rdy: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_word_ack_n |-> $past(!rx_word_ready_n))
    else $error("ack without ready");
endmodule

/* File: bench/mfi_route_model.sv */
// Routing module model: offers queued receive words and collects sent ones.
// Assumes it shares aclk with the node; all handshake pins are active low.
`timescale 1ns/1ps
module mfi_route_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tx_stall,
  output logic             rx_word_ready_n = 1'h1,
  output logic             rx_end_marker_n = 1'h1,
  output logic [31:0]      rx_data = 32'h0,
  input  wire logic        rx_word_ack_n,
  output logic             tx_space_ready_n = 1'h1,
  input  wire logic        tx_word_ack_n,
  input  wire logic        tx_end_marker_n,
  input  wire logic [31:0] tx_data
);
  logic [32:0] rx_q[$];
  logic [32:0] tx_got[$];
  int          rx_gap = 0;

  task automatic push_rx(input logic [32:0] w);
    rx_q.push_back(w);
  endtask

  // Receiver: one word per ack, then a pause so the node sees ready drop
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_ready_n <= 1'h1;
      rx_gap          <= 0;
    end else if (!rx_word_ready_n && rx_word_ack_n === 1'h0) begin
      void'(rx_q.pop_front());
      rx_word_ready_n <= 1'h1;
      rx_gap          <= 4;
    end else if (rx_word_ready_n && rx_gap == 0 && rx_q.size() > 0) begin
      rx_word_ready_n <= 1'h0;
      rx_data         <= rx_q[0][31:0];
      rx_end_marker_n <= ~rx_q[0][32];
    end else if (rx_word_ready_n) begin
      // Released lines keep toggling so a stale sample cannot pass as valid
      rx_data         <= ~rx_data;
      rx_end_marker_n <= ~rx_end_marker_n;
      if (rx_gap > 0) rx_gap <= rx_gap - 1;
    end
  end

  // Transmitter: space offered unless stalled; every ack delivers one word
  always @(posedge aclk) begin
    tx_space_ready_n <= !aresetn || tx_stall;
    if (aresetn && tx_word_ack_n === 1'h0) tx_got.push_back({~tx_end_marker_n, tx_data});
  end
endmodule

/* File: bench/mfi_top_bench.sv */
// Self-checking bench for the message FIFO interface with shallow FIFOs.
// Assumes the routing model on aclk; AXI4-Lite driven after rising edges.
`timescale 1ns/1ps
module mfi_top_bench;
  localparam logic [15:0] LO = mfi_pkg::ADR_FIFO_LO;
  localparam logic [15:0] HI = mfi_pkg::ADR_FIFO_HI;
  localparam logic [15:0] ST = mfi_pkg::ADR_STATUS;
  logic        aclk = 1'h0, aresetn = 1'h0, tx_stall = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, rxd, txd, rd;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid, pres, irq;
  logic        rrdy_n, rend_n, rx_word_ack_n_n, trdy_n, tack_n, tend_n;
  int          mismatches = 0, tests_run = 0, n, sz;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  mfi_top #(.DEPTH(4), .AW(2)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_word_ready_n(rrdy_n), .rx_end_marker_n(rend_n), .rx_data(rxd), .rx_word_ack_n(rx_word_ack_n_n),
    .tx_space_ready_n(trdy_n), .tx_word_ack_n(tack_n), .tx_end_marker_n(tend_n),
    .tx_data(txd), .msg_end_present(pres), .end_irq(irq));

  mfi_route_model MODEL (.aclk(aclk), .aresetn(aresetn), .tx_stall(tx_stall),
    .rx_word_ready_n(rrdy_n), .rx_end_marker_n(rend_n), .rx_data(rxd), .rx_word_ack_n(rx_word_ack_n_n),
    .tx_space_ready_n(trdy_n), .tx_word_ack_n(tack_n), .tx_end_marker_n(tend_n),
    .tx_data(txd));

  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write; c counts edges from the address handshake to the response
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r, output int c);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    @(negedge aclk);
    while (!(awready === 1'h1 && wready === 1'h1)) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    bready  <= 1'h1;
    c = 0;
    @(negedge aclk);
    while (bvalid !== 1'h1) begin
      @(posedge aclk);
      c++;
      @(negedge aclk);
    end
    r = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r,
                        output int c);
    araddr  <= a;
    arvalid <= 1'h1;
    @(negedge aclk);
    while (arready !== 1'h1) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'h0;
    rready  <= 1'h1;
    c = 0;
    @(negedge aclk);
    while (rvalid !== 1'h1) begin
      @(posedge aclk);
      c++;
      @(negedge aclk);
    end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask

  task automatic t_reset;
    chk("link acks idle", 33'h3, 33'({rx_word_ack_n_n, tack_n}));
    chk("end present idle", 33'h0, 33'(pres));
    axi_rd(ST, rd, rsp, n);
    chk("status after reset", 33'h0C, 33'(rd[5:0]));
  endtask

  // Fill the transmit FIFO while the module stalls, then let it drain
  task automatic t_tx;
    for (int i = 0; i < 4; i++) begin
      axi_wr(i == 3 ? HI : LO, 32'hA5A5_0000 + i, 4'hF, rsp, n);
      chk("write resp", 33'(mfi_pkg::RESP_OKAY), 33'(rsp));
      chk("write clocks", i == 0 ? 33'h5 : 33'h2, 33'(n));
    end
    axi_rd(ST, rd, rsp, n);
    chk("tx full", 33'h1, 33'(rd[mfi_pkg::ST_TX_FULL]));
    fork
      begin
        repeat (30) @(posedge aclk);
        tx_stall <= 1'h0;
      end
    join_none
    axi_wr(LO, 32'hA5A5_0004, 4'hF, rsp, n);
    chk("write held while full", 33'h1, 33'(n > 30));
    repeat (60) @(posedge aclk);
    chk("words sent", 33'h5, 33'(MODEL.tx_got.size()));
    for (int i = 0; i < 5; i++) begin
      chk("sent word", {i == 3, 32'hA5A5_0000 + i}, MODEL.tx_got[i]);
    end
  endtask

  // Receive a framed message, watch the end count, flag and interrupt
  task automatic t_rx;
    MODEL.push_rx({1'h0, 32'h1234_5678});
    MODEL.push_rx({1'h1, 32'h9ABC_DEF0});
    n = 0;
    while (pres !== 1'h1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    chk("end present", 33'h1, 33'(pres));
    chk("irq masked", 33'h0, 33'(irq));
    axi_wr(mfi_pkg::ADR_CTRL, 32'h2, 4'hF, rsp, n);
    chk("irq enabled", 33'h1, 33'(irq));
    axi_rd(LO, rd, rsp, n);
    chk("rx word", 33'h1234_5678, 33'(rd));
    chk("read clocks first", 33'h5, 33'(n));
    axi_rd(HI, rd, rsp, n);
    chk("rx end word", 33'h9ABC_DEF0, 33'(rd));
    chk("read clocks next", 33'h3, 33'(n));
    axi_rd(ST, rd, rsp, n);
    chk("end flags", 33'h2, 33'(rd[1:0]));
    chk("irq gone", 33'h0, 33'(irq));
    axi_wr(mfi_pkg::ADR_CTRL, 32'h0, 4'hF, rsp, n);
    axi_rd(ST, rd, rsp, n);
    chk("last end kept", 33'h1, 33'(rd[mfi_pkg::ST_LAST_END]));
    axi_wr(LO, 32'h0F0F_0F0F, 4'hF, rsp, n);
    axi_rd(ST, rd, rsp, n);
    chk("last end cleared", 33'h0, 33'(rd[mfi_pkg::ST_LAST_END]));
  endtask

  // Partial write and unmapped read are refused
  task automatic t_err;
    repeat (20) @(posedge aclk);
    chk("fresh word sent", {1'h0, 32'h0F0F_0F0F}, MODEL.tx_got[MODEL.tx_got.size()-1]);
    axi_wr(mfi_pkg::ADR_CTRL, 32'h1, 4'hF, rsp, n);
    axi_rd(mfi_pkg::ADR_CTRL, rd, rsp, n);
    chk("module master bit", 33'h1, 33'(rd));
    axi_wr(mfi_pkg::ADR_CTRL, 32'h0, 4'hF, rsp, n);
    sz = MODEL.tx_got.size();
    axi_wr(LO, 32'h5555_AAAA, 4'h3, rsp, n);
    chk("partial write", 33'(mfi_pkg::RESP_SLVERR), 33'(rsp));
    axi_rd(16'h4000, rd, rsp, n);
    chk("unmapped resp", 33'(mfi_pkg::RESP_SLVERR), 33'(rsp));
    chk("unmapped data", 33'h0, 33'(rd));
    repeat (20) @(posedge aclk);
    chk("partial not sent", 33'(sz), 33'(MODEL.tx_got.size()));
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    end_of_test();
  end

  // Whole run needs under a thousand cycles; a hang ends it far later
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
endmodule
